// file: lamd_pkg.sv
/*
  constants, types and register map of the legacy address map decoder.
  assumes a 32-bit physical address and a 32-bit apb register port.
*/
`default_nettype none
package lamd_pkg;
   // ---------------------------------------------------------------
   // address ranges
   // ---------------------------------------------------------------
   localparam logic [31:0] VID_LOW_BASE   = 32'h000a_0000;
   localparam logic [31:0] MONO_BASE      = 32'h000b_0000;
   localparam logic [31:0] VID_HIGH_BASE  = 32'h000b_8000;
   localparam logic [31:0] VID_HIGH_LAST  = 32'h000b_ffff;
   localparam logic [31:0] EXP_BASE       = 32'h000c_0000;
   localparam logic [31:0] EBIOS_BASE     = 32'h000e_0000;
   localparam logic [31:0] SBIOS_BASE     = 32'h000f_0000;
   localparam logic [31:0] SBIOS_LAST     = 32'h000f_ffff;
   localparam logic [31:0] HOLE_BASE      = 32'h00f0_0000;
   localparam logic [31:0] HOLE_LAST      = 32'h00ff_ffff;
   localparam logic [31:0] SEG16K_BYTES   = 32'h0000_4000;
   localparam int          SHADOW_SEGS    = 13;
   // monochrome adapter i/o ports
   localparam logic [15:0] IO_MONO_P0     = 16'h03b4;
   localparam logic [15:0] IO_MONO_P1     = 16'h03b5;
   localparam logic [15:0] IO_MONO_P2     = 16'h03b8;
   localparam logic [15:0] IO_MONO_P3     = 16'h03b9;
   localparam logic [15:0] IO_MONO_P4     = 16'h03ba;
   localparam logic [15:0] IO_MONO_P5     = 16'h03bf;
   // top segment sizes in bytes, by size code
   localparam logic [31:0] TOP_SMM_SEGMENT_128K      = 32'h0002_0000;
   localparam logic [31:0] TOP_SMM_SEGMENT_256K      = 32'h0004_0000;
   localparam logic [31:0] TOP_SMM_SEGMENT_512K      = 32'h0008_0000;
   localparam logic [31:0] TOP_SMM_SEGMENT_1M        = 32'h0010_0000;
   // ---------------------------------------------------------------
   // register map (byte offsets)
   // ---------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_SHADOW     = 8'h04;
   localparam logic [7:0]  REG_TOLM       = 8'h08;
   localparam logic [7:0]  REG_SMM        = 8'h0c;
   localparam logic [7:0]  REG_ROWB       = 8'h10;
   localparam logic [7:0]  REG_STATUS     = 8'h14;
   // control fields
   localparam int          CTRL_GRAPHICS_LEGACY_ENABLE_BIT = 0;
   localparam int          CTRL_MONO_BIT  = 1;
   localparam int          CTRL_HOLE_BIT  = 2;
   // smm fields
   localparam int          SMM_GLOBAL_BIT = 0;
   localparam int          SMM_OPEN_BIT   = 1;
   localparam int          SMM_HIGH_BIT   = 2;
   localparam int          SMM_TEN_BIT    = 3;
   localparam int          SMM_SZ_LSB     = 4;
   // reset values
   localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
   localparam logic [25:0] SHADOW_RST     = 26'h000_0000;
   localparam logic [31:0] TOLM_RST       = 32'h0100_0000;
   localparam logic [31:0] SMM_RST        = 32'h0000_0000;
   localparam logic [7:0]  ROWB_RST       = 8'h00;

   typedef enum logic [1:0] {LAMD_DRAM, LAMD_HUB, LAMD_GFX, LAMD_SPECIAL} lamd_dest_e;
   typedef enum logic [1:0] {LAMD_CPU, LAMD_FROM_HUB, LAMD_FROM_GFX} lamd_src_e;
endpackage : lamd_pkg
`default_nettype wire

// file: lamd_cfg_if.sv
/*
  configuration bundle from the register file to the route logic.
  assumes one writer (the register file) and one reader.
*/
`timescale 1ns/1ps
`default_nettype none
interface lamd_cfg_if;
   logic        vga_en;
   logic        mono_present;
   logic        hole_en;
   logic [25:0] shadow_attr;
   logic [31:0] tolm;
   logic [31:0] smm_ctl;
   modport regs (output vga_en, mono_present, hole_en, shadow_attr, tolm, smm_ctl);
   modport route (input vga_en, mono_present, hole_en, shadow_attr, tolm, smm_ctl);
endinterface : lamd_cfg_if
`default_nettype wire

// file: lamd_regs.sv
/*
  apb register file of the decoder; drives the config bundle.
  assumes a well behaved apb master; zero wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module lamd_regs
   import lamd_pkg::*;
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   // apb
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [31:0] i_status,
   output logic      [31:0] o_prdata,
   output logic             o_pslverr,
   // config
   lamd_cfg_if.regs         cfg
);
   logic [31:0] ctrl_q;
   logic [25:0] shadow_q;
   logic [31:0] tolm_q;
   logic [31:0] smm_q;
   logic [7:0]  rowb_q;
   logic [31:0] rdata_d;
   logic        hit_d;
   wire         wr_en    = i_psel & i_penable & i_pwrite;
   wire         setup    = i_psel & ~i_penable;
   wire         rd_setup = setup & ~i_pwrite;

   always_comb begin
      hit_d   = 1'b1;
      rdata_d = 32'h0000_0000;
      case (i_paddr)
         REG_CTRL:   rdata_d = {29'h0000_0000, ctrl_q[2:0]};
         REG_SHADOW: rdata_d = {6'h00, shadow_q};
         REG_TOLM:   rdata_d = tolm_q;
         REG_SMM:    rdata_d = {26'h000_0000, smm_q[5:0]};
         REG_ROWB:   rdata_d = {24'h00_0000, rowb_q};
         REG_STATUS: rdata_d = i_status;
         default:    hit_d   = 1'b0;
      endcase
   end

   // new values steer the next decoded transaction [RQ21]
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q   <= CTRL_RST;
         shadow_q <= SHADOW_RST; // bios segment starts disabled [RQ9]
         tolm_q   <= TOLM_RST;
         smm_q    <= SMM_RST;
         rowb_q   <= ROWB_RST;
      end else if (wr_en) begin
         case (i_paddr)
            REG_CTRL:   ctrl_q   <= i_pwdata;
            REG_SHADOW: shadow_q <= i_pwdata[25:0];
            REG_TOLM:   tolm_q   <= {i_pwdata[31:16], 16'h0000};
            REG_SMM:    smm_q    <= i_pwdata;
            REG_ROWB:   rowb_q   <= i_pwdata[7:0]; // software keeps it valid [RQ17]
            default:    ;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         // latched at setup so data and error stand beside pready
         o_prdata  <= rd_setup ? rdata_d : 32'h0000_0000;
         o_pslverr <= setup & ~hit_d;
      end
   end

   assign cfg.vga_en       = ctrl_q[CTRL_GRAPHICS_LEGACY_ENABLE_BIT];
   assign cfg.mono_present = ctrl_q[CTRL_MONO_BIT];
   assign cfg.hole_en      = ctrl_q[CTRL_HOLE_BIT];
   assign cfg.shadow_attr  = shadow_q;
   assign cfg.tolm         = tolm_q;
   assign cfg.smm_ctl      = smm_q;
endmodule : lamd_regs
`default_nettype wire

// file: lamd_decoder.sv
/*
  legacy address map decoder: routes each transaction to dram, hub or
  graphics port, or marks it for special termination.
  assumes a request is a one-cycle strobe; the answer is one cycle later.
*/
// Implementation choices: the address map and the APB slave port.
// How it works
// [RQ1] 32-bit address: legacy below 1 MB, extended above
// [RQ2] video range goes to hub by default
// [RQ3] legacy enable sends video ranges to graphics
// [RQ4] monochrome present keeps monochrome range on hub
// [RQ5] monochrome i/o ports go to hub
// [RQ6] software sets at most one legacy enable
// [RQ7] expansion region: eight 16 KB segments, four states
// [RQ8] extended bios: four segments, read/write attributes
// [RQ9] system bios one segment, disabled at reset
// [RQ10] memory hole relays 15-16 MB to hub
// [RQ11] top segment sized 128K to 1M
// [RQ12] top segment reaches dram only when permitted
// [RQ13] smm disabled: range is ordinary dram
// [RQ14] non-smm top segment access specially terminated
// [RQ15] hub and graphics masters never reach smm
// [RQ16] top of memory bounds dram; segment below it
// [RQ17] software programs last row boundary register
// [RQ18] special termination: reads address 0, writes dropped
// [RQ19] above top of memory subtractively to hub
// [RQ20] shadow access to dram only if attribute set
// [RQ21] route is combinational from address and config
`timescale 1ns/1ps
`default_nettype none
module lamd_decoder
   import lamd_pkg::*;
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   // apb register port
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // transaction request
   input  wire logic        i_req_valid,
   input  wire logic [31:0] i_req_addr,
   input  wire logic        i_req_write,
   input  wire logic        i_req_io,
   input  wire logic        i_req_smm_code,
   input  wire logic [1:0]  i_req_src,
   // routing answer
   output logic             o_rt_valid,
   output logic [1:0]       o_rt_dest,
   output logic [31:0]      o_rt_addr,
   output logic             o_rt_drop_write,
   output logic             o_rt_io_claim
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   lamd_cfg_if cfg ();
   logic [31:0] status_w;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_d;

   lamd_regs u_regs (
      .i_mclk    (i_mclk),
      .i_rst     (i_rst),
      .i_psel    (i_psel),
      .i_penable (i_penable),
      .i_pwrite  (i_pwrite),
      .i_paddr   (i_paddr),
      .i_pwdata  (i_pwdata),
      .i_status  (status_w),
      .o_prdata  (o_prdata),
      .o_pslverr (o_pslverr),
      .cfg       (cfg)
   );

   // ready only in the cycle after setup: registers answer in the first access cycle
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) o_pready <= 1'b0;
      else       o_pready <= i_psel & ~i_penable;
   end

   // ---------------------------------------------------------------
   // range decode
   // ---------------------------------------------------------------
   wire        is_cpu    = (i_req_src == 2'(LAMD_CPU));
   wire [31:0] a         = i_req_addr; // full 4 GB space [RQ1]
   wire        in_vlow   = (a >= VID_LOW_BASE)  & (a < MONO_BASE);
   wire        in_mono   = (a >= MONO_BASE)     & (a < VID_HIGH_BASE);
   wire        in_vhigh  = (a >= VID_HIGH_BASE) & (a <= VID_HIGH_LAST);
   wire        in_video  = in_vlow | in_mono | in_vhigh;
   wire        in_shadow = (a >= EXP_BASE) & (a <= SBIOS_LAST);
   wire        in_hole   = (a >= HOLE_BASE) & (a <= HOLE_LAST);
   wire [31:0] shadow_off = a - EXP_BASE;
   // segment index: 0..7 expansion, 8..11 ext bios, 12 system bios
   wire [3:0]  seg_raw   = shadow_off[17:14];
   wire [3:0]  seg_idx   = (a >= SBIOS_BASE) ? 4'hc : seg_raw; // [RQ9]
   wire [1:0]  seg_attr  = cfg.shadow_attr[2*seg_idx +: 2];    // bit0 read, bit1 write
   wire        seg_dram  = i_req_write ? seg_attr[1] : seg_attr[0]; // [RQ7] [RQ8] [RQ20]
   wire        ext_bios  = (a >= EBIOS_BASE) & (a < SBIOS_BASE);

   // top segment
   wire [1:0]  sz_code   = cfg.smm_ctl[SMM_SZ_LSB +: 2];
   logic [31:0] top_segment_size_field;
   always_comb begin
      case (sz_code) // [RQ11]
         2'h0:    top_segment_size_field = TOP_SMM_SEGMENT_128K;
         2'h1:    top_segment_size_field = TOP_SMM_SEGMENT_256K;
         2'h2:    top_segment_size_field = TOP_SMM_SEGMENT_512K;
         default: top_segment_size_field = TOP_SMM_SEGMENT_1M;
      endcase
   end
   wire [31:0] top_smm_segment_base = cfg.tolm - top_segment_size_field; // [RQ16]
   wire        in_top_smm_segment   = (a >= top_smm_segment_base) & (a < cfg.tolm);
   wire        above_tom = (a >= cfg.tolm);
   wire        smm_glob  = cfg.smm_ctl[SMM_GLOBAL_BIT];
   wire        top_smm_segment_on   = smm_glob & cfg.smm_ctl[SMM_HIGH_BIT] & cfg.smm_ctl[SMM_TEN_BIT];
   wire        smm_ok    = is_cpu & (cfg.smm_ctl[SMM_OPEN_BIT] | i_req_smm_code);

   // monochrome i/o ports
   wire [15:0] io_a      = a[15:0];
   wire        io_mono   = (io_a == IO_MONO_P0) | (io_a == IO_MONO_P1)
                         | (io_a == IO_MONO_P2) | (io_a == IO_MONO_P3)
                         | (io_a == IO_MONO_P4) | (io_a == IO_MONO_P5);
   wire        io_hit    = i_req_io & cfg.mono_present & io_mono & (a[31:16] == 16'h0000);

   // ---------------------------------------------------------------
   // route selection, purely combinational
   // ---------------------------------------------------------------
   lamd_dest_e dest_d;
   always_comb begin // [RQ21]
      if (i_req_io)
         dest_d = LAMD_HUB; // [RQ5]
      else if (in_mono & cfg.mono_present)
         dest_d = LAMD_HUB; // [RQ4]
      else if (in_video)
         dest_d = cfg.vga_en ? LAMD_GFX : LAMD_HUB; // [RQ2] [RQ3]
      else if (in_shadow)
         dest_d = seg_dram ? LAMD_DRAM : LAMD_HUB; // [RQ20]
      else if (in_hole & cfg.hole_en)
         dest_d = LAMD_HUB; // [RQ10]
      else if (in_top_smm_segment & top_smm_segment_on)
         dest_d = smm_ok ? LAMD_DRAM : LAMD_SPECIAL; // [RQ12] [RQ14] [RQ15]
      else if (above_tom)
         dest_d = LAMD_HUB; // [RQ19]
      else
         dest_d = LAMD_DRAM; // [RQ13]
   end

   // special termination reads address 0 and drops writes [RQ18]
   wire        special_d = (dest_d == LAMD_SPECIAL);
   wire [31:0] addr_d    = special_d ? 32'h0000_0000 : a;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rt_valid      <= 1'b0;
         o_rt_dest       <= 2'(LAMD_HUB);
         o_rt_addr       <= 32'h0000_0000;
         o_rt_drop_write <= 1'b0;
         o_rt_io_claim   <= 1'b0;
      end else begin
         o_rt_valid      <= i_req_valid;
         o_rt_dest       <= 2'(dest_d);
         o_rt_addr       <= addr_d;
         o_rt_drop_write <= i_req_valid & special_d & i_req_write; // [RQ18]
         o_rt_io_claim   <= i_req_valid & io_hit; // [RQ5]
      end
   end

   // count of special terminations, readable for diagnosis
   assign cnt_d = cnt_q + 4'(i_req_valid & special_d);
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) cnt_q <= 4'h0;
      else       cnt_q <= cnt_d;
   end
   // software keeps only one legacy enable set, so no arbitration here [RQ6]
   assign status_w = {26'h000_0000, ext_bios, top_smm_segment_on, cnt_q};

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_video_gfx;
      @(posedge i_mclk) disable iff (i_rst)
         (i_req_valid & ~i_req_io & in_vlow & cfg.vga_en) |=> (o_rt_dest == 2'(LAMD_GFX));
   endproperty
   a_video_gfx: assert property (p_video_gfx) else $error("video not to graphics"); // [RQ3]

   property p_video_hub;
      @(posedge i_mclk) disable iff (i_rst)
         (i_req_valid & ~i_req_io & in_vhigh & ~cfg.vga_en) |=> (o_rt_dest == 2'(LAMD_HUB));
   endproperty
   a_video_hub: assert property (p_video_hub) else $error("video not to hub"); // [RQ2]

   property p_mono;
      @(posedge i_mclk) disable iff (i_rst)
         (i_req_valid & ~i_req_io & in_mono & cfg.mono_present) |=> (o_rt_dest == 2'(LAMD_HUB));
   endproperty
   a_mono: assert property (p_mono) else $error("mono range not to hub"); // [RQ4]

   property p_io_claim;
      @(posedge i_mclk) disable iff (i_rst)
         (i_req_valid & io_hit) |=> (o_rt_io_claim & (o_rt_dest == 2'(LAMD_HUB)));
   endproperty
   a_io_claim: assert property (p_io_claim) else $error("mono port not claimed"); // [RQ5]

   property p_hole;
      @(posedge i_mclk) disable iff (i_rst)
         (i_req_valid & ~i_req_io & in_hole & cfg.hole_en) |=> (o_rt_dest == 2'(LAMD_HUB));
   endproperty
   a_hole: assert property (p_hole) else $error("hole not to hub"); // [RQ10]

   property p_no_smm_hub;
      @(posedge i_mclk) disable iff (i_rst)
         (i_req_valid & ~i_req_io & ~is_cpu & in_top_smm_segment & top_smm_segment_on & ~in_shadow & ~in_video
          & ~(in_hole & cfg.hole_en)) |=> (o_rt_dest == 2'(LAMD_SPECIAL));
   endproperty
   a_no_smm_hub: assert property (p_no_smm_hub) else $error("hub reached smm"); // [RQ15]

   property p_special_zero;
      @(posedge i_mclk) disable iff (i_rst)
         (o_rt_valid & (o_rt_dest == 2'(LAMD_SPECIAL))) |-> (o_rt_addr == 32'h0000_0000);
   endproperty
   a_special_zero: assert property (p_special_zero) else $error("special not addr 0"); // [RQ18]

   property p_bios_reset;
      @(posedge i_mclk) disable iff (i_rst)
         (i_req_valid & ~i_req_io & (a >= SBIOS_BASE) & (a <= SBIOS_LAST)
          & (cfg.shadow_attr[25:24] == 2'h0)) |=> (o_rt_dest == 2'(LAMD_HUB));
   endproperty
   a_bios_reset: assert property (p_bios_reset) else $error("bios shadow leak"); // [RQ9]

   property p_pready;
      @(posedge i_mclk) disable iff (i_rst)
         (i_psel & ~i_penable) |=> o_pready ##1 ~o_pready;
   endproperty
   a_pready: assert property (p_pready) else $error("pready timing");

   c_gfx:     cover property (@(posedge i_mclk) o_rt_valid & (o_rt_dest == 2'(LAMD_GFX)));
   c_special: cover property (@(posedge i_mclk) o_rt_valid & (o_rt_dest == 2'(LAMD_SPECIAL)));
   c_shadow:  cover property (@(posedge i_mclk) i_req_valid & in_shadow & seg_dram);
   c_ioclaim: cover property (@(posedge i_mclk) o_rt_io_claim);
endmodule : lamd_decoder
`default_nettype wire

// file: lamd_req_model.sv
/*
  far-side requester model: one transaction strobe, then the route answer.
  assumes the decoder answers exactly one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module lamd_req_model (
   // clock
   input  wire logic        i_mclk,
   // request to decoder
   output logic             o_req_valid,
   output logic [31:0]      o_req_addr,
   output logic             o_req_write,
   output logic             o_req_io,
   output logic             o_req_smm_code,
   output logic [1:0]       o_req_src,
   // answer from decoder
   input  wire logic        i_rt_valid,
   input  wire logic [1:0]  i_rt_dest,
   input  wire logic [31:0] i_rt_addr,
   input  wire logic        i_rt_drop_write,
   input  wire logic        i_rt_io_claim
);
   initial begin
      o_req_valid    = 1'b0;
      o_req_addr     = 32'h0000_0000;
      o_req_write    = 1'b0;
      o_req_io       = 1'b0;
      o_req_smm_code = 1'b0;
      o_req_src      = 2'h0;
   end

   // ---------------------------------------------------------------
   // one request, answer sampled once settled
   // ---------------------------------------------------------------
   task automatic send(input logic [31:0] a, input logic w, input logic io,
                       input logic code, input logic [1:0] s,
                       output logic [4:0] flags, output logic [31:0] ra);
      @(posedge i_mclk);
      o_req_valid    <= 1'b1;
      o_req_addr     <= io ? {16'h0000, a[15:0]} : a;
      o_req_write    <= w;
      o_req_io       <= io;
      o_req_smm_code <= code & (s == 2'h0);
      o_req_src      <= s;
      @(posedge i_mclk);
      o_req_valid    <= 1'b0;
      // idle address is inverted so a stale value never looks valid
      o_req_addr     <= ~o_req_addr;
      #1;
      flags = {i_rt_valid, i_rt_drop_write, i_rt_io_claim, i_rt_dest};
      ra    = i_rt_addr;
   endtask : send
endmodule : lamd_req_model
`default_nettype wire

// file: tb.sv
/*
  self-checking bench of the legacy address map decoder over apb.
  assumes zero-wait apb and a one-cycle route answer.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
   import lamd_pkg::*;
();
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rq_v, rq_w, rq_io, rq_code, rt_v, rt_drop, rt_claim;
   logic [31:0] rq_a, rt_a;
   logic [1:0]  rq_s, rt_d;
   int          errors = 0;
   int          tests_run = 0;
   logic [15:0] ports [6] = '{IO_MONO_P0, IO_MONO_P1, IO_MONO_P2,
                              IO_MONO_P3, IO_MONO_P4, IO_MONO_P5};
   logic [31:0] sizes [4] = '{TOP_SMM_SEGMENT_128K, TOP_SMM_SEGMENT_256K, TOP_SMM_SEGMENT_512K, TOP_SMM_SEGMENT_1M};
   logic [31:0] tolm = 32'h0200_0000;

   always #5 mclk = ~mclk;

   lamd_decoder dut (.i_mclk(mclk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_req_valid(rq_v), .i_req_addr(rq_a),
      .i_req_write(rq_w), .i_req_io(rq_io), .i_req_smm_code(rq_code), .i_req_src(rq_s),
      .o_rt_valid(rt_v), .o_rt_dest(rt_d), .o_rt_addr(rt_a), .o_rt_drop_write(rt_drop),
      .o_rt_io_claim(rt_claim));

   lamd_req_model req (.i_mclk(mclk), .o_req_valid(rq_v), .o_req_addr(rq_a),
      .o_req_write(rq_w), .o_req_io(rq_io), .o_req_smm_code(rq_code), .o_req_src(rq_s),
      .i_rt_valid(rt_v), .i_rt_dest(rt_d), .i_rt_addr(rt_a), .i_rt_drop_write(rt_drop),
      .i_rt_io_claim(rt_claim));

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   // ---------------------------------------------------------------
   // apb master: setup, then access until pready
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         end_of_test();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, experr});
   endtask : rdc

   // special termination answers address 0 and drops writes
   task automatic tr(input logic [31:0] a, input logic w, input logic io, input logic code,
                     input logic [1:0] s, input lamd_dest_e d, input logic claim);
      logic [4:0]  f;
      logic [31:0] ra;
      req.send(a, w, io, code, s, f, ra);
      chk({27'h0, f}, {27'h0, 1'b1, w & (d == LAMD_SPECIAL), claim, d});
      chk(ra, (d == LAMD_SPECIAL) ? 32'h0000_0000 : a);
   endtask : tr

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rdc(REG_CTRL, CTRL_RST, 1'b0);
      rdc(REG_SHADOW, {6'h00, SHADOW_RST}, 1'b0);
      rdc(REG_TOLM, TOLM_RST, 1'b0);
      rdc(REG_SMM, SMM_RST, 1'b0);
      rdc(8'h18, 32'h0000_0000, 1'b1);
      tr(VID_LOW_BASE, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(MONO_BASE, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(VID_HIGH_LAST, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      wr(REG_CTRL, 32'h0000_0001);
      tr(VID_LOW_BASE, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_GFX, 1'b0);
      tr(MONO_BASE, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_GFX, 1'b0);
      tr(VID_HIGH_BASE, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_GFX, 1'b0);
      wr(REG_CTRL, 32'h0000_0003);
      tr(VID_HIGH_BASE - 1, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(VID_HIGH_BASE, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_GFX, 1'b0);
      tr(MONO_BASE - 1, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_GFX, 1'b0);
      foreach (ports[i]) tr({16'h0, ports[i]}, 1'b0, 1'b1, 1'b0, 2'h0, LAMD_HUB, 1'b1);
      tr(32'h0000_03b6, 1'b0, 1'b1, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      // shadow: c0 read only, dc write only, e0 and f0 read/write
      tr(SBIOS_BASE, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(SBIOS_LAST, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      wr(REG_SHADOW, 32'h0303_8001);
      tr(EXP_BASE, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_DRAM, 1'b0);
      tr(EXP_BASE, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(EXP_BASE + SEG16K_BYTES, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(EBIOS_BASE - 1, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_DRAM, 1'b0);
      tr(EBIOS_BASE - 1, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(EBIOS_BASE, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_DRAM, 1'b0);
      tr(EBIOS_BASE + SEG16K_BYTES, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(SBIOS_LAST, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_DRAM, 1'b0);
      tr(HOLE_BASE, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_DRAM, 1'b0);
      wr(REG_CTRL, 32'h0000_0004);
      tr(HOLE_BASE, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(HOLE_LAST, 1'b1, 1'b0, 1'b0, 2'h1, LAMD_HUB, 1'b0);
      tr(HOLE_BASE - 1, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_DRAM, 1'b0);
      tr(32'h0000_03b4, 1'b0, 1'b1, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      // top of memory moved above the hole
      wr(REG_TOLM, tolm);
      wr(REG_ROWB, 32'h0000_0001);
      tr(tolm, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      tr(tolm - 1, 1'b0, 1'b0, 1'b0, 2'h1, LAMD_DRAM, 1'b0);
      tr(32'hffff_fff0, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_HUB, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(REG_SMM, 32'h0000_000d | (i << SMM_SZ_LSB));
         tr(tolm - sizes[i], 1'b0, 1'b0, 1'b0, 2'h0, LAMD_SPECIAL, 1'b0);
         tr(tolm - sizes[i] - 1, 1'b0, 1'b0, 1'b0, 2'h0, LAMD_DRAM, 1'b0);
         tr(tolm - sizes[i], 1'b1, 1'b0, 1'b1, 2'h0, LAMD_DRAM, 1'b0);
      end
      wr(REG_SMM, 32'h0000_003f);
      tr(tolm - 1, 1'b1, 1'b0, 1'b0, 2'h0, LAMD_DRAM, 1'b0);
      tr(tolm - 1, 1'b0, 1'b0, 1'b0, 2'h1, LAMD_SPECIAL, 1'b0);
      tr(tolm - 1, 1'b1, 1'b0, 1'b0, 2'h2, LAMD_SPECIAL, 1'b0);
      wr(REG_SMM, 32'h0000_0037);
      tr(tolm - 1, 1'b0, 1'b0, 1'b0, 2'h1, LAMD_DRAM, 1'b0);
      wr(REG_SMM, 32'h0000_003b);
      tr(tolm - 1, 1'b1, 1'b0, 1'b0, 2'h2, LAMD_DRAM, 1'b0);
      rdc(REG_ROWB, 32'h0000_0001, 1'b0);
      rdc(REG_STATUS, 32'h0000_0006, 1'b0);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
